// *** design/agu_pkg.sv ***
package agu_pkg;
    // ==================== widths ====================
    localparam int ADDR_W = 32;
    localparam int SEL_W = 16;
    localparam int NUM_GPR = 8;
    localparam int NUM_SEG = 6;
    // general register holding the stack pointer, never an index
    localparam logic [2:0] STACK_PTR_IDX = 3'h4;
    // ==================== i/o space ====================
    localparam logic [31:0] IO_ADDR_MASK = 32'h0000_ffff;
    localparam logic [15:0] CFG_PORT_INDEX = 16'h0022;
    localparam logic [15:0] CFG_PORT_DATA = 16'h0023;
    // ==================== access sizes ====================
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_DWORD = 2'h2;
    // ==================== reset values and mode codes ====================
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [3:0] BE_RESET = 4'h0;
    localparam logic [2:0] MODE_REAL = 3'h0;
    localparam logic [2:0] MODE_PROT = 3'h1;
    localparam logic [2:0] MODE_IO = 3'h2;
endpackage : agu_pkg

// *** design/address_generation_unit.sv ***
`timescale 1ns/1ps
// What this block does
// - memory accessed as byte, word or dword, low byte at lowest address
// - item address is address of its least significant byte
// - separate 64 KByte port space with 8, 16 or 32-bit transfers
// - memory/io select driven low during any port in or out
// - port addresses confined to 0 through ffff, upper bits zero
// - ports 22h and 23h reach the internal configuration registers
// - offset sums base, scaled index and displacement from eight registers
// - stack pointer register never serves as an index
// - index scaled by 1, 2, 4 or 8 as a left shift
// - displacement is an instruction immediate up to 32 bits
// - eight combinations of base, index, scale and displacement supported
// - real mode address is segment times 16 plus 16-bit offset
// - real mode sum zero-extended to 32 bits
// - real mode carry kept, giving 21 significant bits
// - protected mode linear address is hidden segment base plus offset
// - paging off passes linear unchanged, paging on hands it to translation
// - six segment registers each hold a 16-bit selector used to fetch descriptor
// - descriptor base, limit, attributes cached in hidden, unreadable storage
// - paging active only when paging and protection enable both set
module address_generation_unit
    import agu_pkg::*;
#(
    parameter int DISP_W = 32
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    // general register write port
    input wire logic i_gpr_we,
    input wire logic [2:0] i_gpr_wsel,
    input wire logic [31:0] i_gpr_wdata,
    // segment register load, descriptor supplied by the descriptor fetch
    input wire logic i_seg_load,
    input wire logic [2:0] i_seg_lsel,
    input wire logic [15:0] i_seg_selector,
    input wire logic [31:0] i_desc_base,
    input wire logic [31:0] i_desc_limit,
    input wire logic [11:0] i_desc_attr,
    // control bits
    input wire logic i_paging_enable_bit,
    input wire logic i_protection_enable_bit,
    // address request
    input wire logic i_req,
    input wire logic i_is_port_io,
    input wire logic [1:0] i_size,
    input wire logic i_use_base,
    input wire logic [2:0] i_base_sel,
    input wire logic i_use_index,
    input wire logic [2:0] i_index_sel,
    input wire logic [1:0] i_scale,
    input wire logic i_use_disp,
    input wire logic [DISP_W-1:0] i_disp,
    input wire logic [2:0] i_seg_sel,
    // results
    output logic o_valid,
    output logic [31:0] o_addr,
    output logic [3:0] o_byte_en,
    output logic o_mem_io_n,
    output logic o_cfg_access,
    output logic o_to_paging,
    output logic o_index_fault,
    output logic [15:0] o_selector,
    output logic [31:0] o_seg_limit,
    output logic [11:0] o_seg_attr
);

    // ==================== types ====================
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
        logic [11:0] attr;
        logic [15:0] sel;
    } seg_t;

    typedef struct packed {
        logic [NUM_GPR-1:0][31:0] gpr;
        seg_t [NUM_SEG-1:0] seg;
        logic valid;
        logic [31:0] addr;
        logic [3:0] byte_en;
        logic mem_io_n;
        logic cfg_access;
        logic to_paging;
        logic index_fault;
        logic [15:0] selector;
        logic [31:0] seg_limit;
        logic [11:0] seg_attr;
    } state_t;

    // ==================== reset release ====================
    logic [1:0] rst_sync_q;
    logic rstn;

    // async assert, two flops on release so deassertion is clean
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rstn = rst_sync_q[1];

    // ==================== offset datapath ====================
    state_t state_q, state_d;
    logic [31:0] base_val;
    logic [31:0] index_val;
    logic [31:0] disp_val;
    logic [31:0] offset;
    logic [20:0] real_addr;
    logic [31:0] lin_addr;
    logic [31:0] phys_addr;
    logic paging_on;
    logic index_bad;
    seg_t cur_seg;

    // operand picking and the three-way adder
    always_comb begin
        base_val = i_use_base ? state_q.gpr[i_base_sel] : 32'h0000_0000;
        index_bad = i_use_index && (i_index_sel == STACK_PTR_IDX);
        // the stack pointer slot is forced to zero rather than indexed
        index_val = (i_use_index && !index_bad) ? state_q.gpr[i_index_sel] : 32'h0000_0000;
        index_val = index_val << i_scale;
        disp_val = i_use_disp ? 32'(i_disp) : 32'h0000_0000;
        // any subset of the three enables gives the eight combinations
        offset = base_val + index_val + disp_val;
    end

    // segment and mode address forming
    always_comb begin
        cur_seg = state_q.seg[i_seg_sel];
        // 21-bit sum keeps the carry just above 1 MByte
        real_addr = {1'b0, cur_seg.sel, 4'h0} + {5'h00, offset[15:0]};
        lin_addr = cur_seg.base + offset;
        paging_on = i_paging_enable_bit && i_protection_enable_bit;
        if (!i_protection_enable_bit) begin
            phys_addr = {11'h000, real_addr};
        end else begin
            phys_addr = lin_addr;
        end
    end

    // ==================== next state ====================
    always_comb begin
        state_d = state_q;
        state_d.valid = i_req;
        // register file updates
        if (i_gpr_we) begin
            state_d.gpr[i_gpr_wsel] = i_gpr_wdata;
        end
        // a load latches selector and caches the fetched descriptor
        if (i_seg_load && (i_seg_lsel < 3'(NUM_SEG))) begin
            state_d.seg[i_seg_lsel].sel = i_seg_selector;
            state_d.seg[i_seg_lsel].base = i_desc_base;
            state_d.seg[i_seg_lsel].limit = i_desc_limit;
            state_d.seg[i_seg_lsel].attr = i_desc_attr;
        end
        if (i_req) begin
            state_d.index_fault = index_bad;
            state_d.selector = cur_seg.sel;
            // hidden copy goes only to checking logic, never to software
            state_d.seg_limit = cur_seg.limit;
            state_d.seg_attr = cur_seg.attr;
            case (i_size)
                SIZE_BYTE: state_d.byte_en = 4'h1;
                SIZE_WORD: state_d.byte_en = 4'h3;
                default: state_d.byte_en = 4'hf;
            endcase
            if (i_is_port_io) begin
                // port space skips segmentation and paging entirely
                state_d.addr = offset & IO_ADDR_MASK;
                state_d.mem_io_n = 1'b0;
                state_d.cfg_access = (offset[15:0] == CFG_PORT_INDEX) ||
                                     (offset[15:0] == CFG_PORT_DATA);
                state_d.to_paging = 1'b0;
            end else begin
                // address names the low byte of the item
                state_d.addr = phys_addr;
                state_d.mem_io_n = 1'b1;
                state_d.cfg_access = 1'b0;
                state_d.to_paging = paging_on;
            end
        end
    end

    // ==================== state register ====================
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= '0;
            state_q.mem_io_n <= 1'b1; // out of reset reads as memory space
        end else begin
            state_q <= state_d;
        end
    end

    // ==================== outputs ====================
    assign o_valid = state_q.valid;
    assign o_addr = state_q.addr;
    assign o_byte_en = state_q.byte_en;
    assign o_mem_io_n = state_q.mem_io_n;
    assign o_cfg_access = state_q.cfg_access;
    assign o_to_paging = state_q.to_paging;
    assign o_index_fault = state_q.index_fault;
    assign o_selector = state_q.selector;
    assign o_seg_limit = state_q.seg_limit;
    assign o_seg_attr = state_q.seg_attr;

endmodule : address_generation_unit

// *** dv/address_generation_unit_assertions.sv ***
`timescale 1ns/1ps
// =====
// valid, port, byte lane, real mode, paging and stack index checks
module address_generation_unit_assertions
    import agu_pkg::*;
(
    input wire logic i_clk, i_rstn, i_req, i_is_port_io, i_use_index,
    input wire logic i_paging_enable_bit, i_protection_enable_bit,
    input wire logic [1:0] i_size,
    input wire logic [2:0] i_index_sel,
    input wire logic o_valid, o_mem_io_n, o_cfg_access, o_to_paging, o_index_fault,
    input wire logic [31:0] o_addr,
    input wire logic [3:0] o_byte_en
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_valid_per_req: assert property (i_req |=> o_valid ##1 (o_valid == $past(i_req)))
        else $error("valid timing");
    a_port_io_low: assert property (i_req && i_is_port_io |=> !o_mem_io_n)
        else $error("port not on io");
    a_port_upper_zero: assert property (i_req && i_is_port_io |=> o_addr[31:16] == 16'h0000)
        else $error("port upper bits");
    a_cfg_decode: assert property (i_req && i_is_port_io |=> o_cfg_access == ((o_addr[15:0] | 16'h0001) == CFG_PORT_DATA))
        else $error("cfg decode");
    a_byte_lanes: assert property (i_req |=> o_byte_en == ($past(i_size) == SIZE_BYTE ? 4'h1 :
        $past(i_size) == SIZE_WORD ? 4'h3 : 4'hf)) else $error("byte lanes");
    a_real_upper_zero: assert property (i_req && !i_is_port_io && !i_protection_enable_bit |=> o_addr[31:21] == 11'h000)
        else $error("real upper bits");
    a_paging_gate: assert property (i_req && !i_protection_enable_bit |=> !o_to_paging)
        else $error("paging in real mode");
    a_sp_index: assert property (i_req && i_use_index && i_index_sel == STACK_PTR_IDX |=> o_index_fault)
        else $error("sp index");
endmodule : address_generation_unit_assertions
bind address_generation_unit address_generation_unit_assertions u_chk (.*);

// *** dv/port_device_model.sv ***
`timescale 1ns/1ps
// =====
// far side: port devices latch the address of each io cycle
module port_device_model (
    input wire logic i_clk,
    input wire logic i_valid,
    input wire logic i_mem_io_n,
    input wire logic [31:0] i_addr,
    output logic [15:0] o_port_addr
);
    // only the low 16 lines are decoded by port devices
    always_ff @(posedge i_clk) begin
        if (i_valid && !i_mem_io_n) o_port_addr <= i_addr[15:0];
    end
endmodule : port_device_model

// *** dv/test_address_generation_unit.sv ***
`timescale 1ns/1ps
// =====
// bench
module test_address_generation_unit;
    logic i_clk = 0, i_rstn = 0, gwe = 0, sld = 0, pg = 0, pe = 0, req = 0, pio = 0, ub = 0, ui = 0, ud = 0;
    logic [2:0] wsel = 0, bsel = 0, isel = 0, seg = 0;
    logic [1:0] sc = 0;
    logic [31:0] wd = 0, disp = 0, addr, lim;
    logic [15:0] sel, pa;
    logic vld, mio, cfg, tpg, ifl;
    logic [3:0] be;
    logic [11:0] attr;
    int n_fail = 0, check_count = 0;
    always #25 i_clk = ~i_clk;
    address_generation_unit u_dut (.i_clk, .i_rstn, .i_gpr_we(gwe), .i_gpr_wsel(wsel), .i_gpr_wdata(wd),
        .i_seg_load(sld), .i_seg_lsel(wsel), .i_seg_selector(wd[15:0]), .i_desc_base(wd), .i_desc_limit(~wd),
        .i_desc_attr(wd[11:0]), .i_paging_enable_bit(pg), .i_protection_enable_bit(pe), .i_req(req),
        .i_is_port_io(pio), .i_size(sc), .i_use_base(ub), .i_base_sel(bsel), .i_use_index(ui), .i_index_sel(isel),
        .i_scale(sc), .i_use_disp(ud), .i_disp(disp), .i_seg_sel(seg), .o_valid(vld), .o_addr(addr), .o_byte_en(be),
        .o_mem_io_n(mio), .o_cfg_access(cfg), .o_to_paging(tpg), .o_index_fault(ifl), .o_selector(sel),
        .o_seg_limit(lim), .o_seg_attr(attr));
    port_device_model u_dev (.i_clk, .i_valid(vld), .i_mem_io_n(mio), .i_addr(addr), .o_port_addr(pa));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // l=1 loads a segment, else a general register
    task automatic wr(input logic l, input logic [2:0] s, input logic [31:0] d);
        gwe = !l; sld = l; wsel = s; wd = d;
        @(negedge i_clk);
        gwe = 0; sld = 0;
    endtask : wr
    task automatic rq(input logic p, b, i, d, input logic [1:0] s, input logic [31:0] dv);
        pio = p; ub = b; ui = i; ud = d; sc = s; disp = dv; req = 1;
        @(negedge i_clk);
        req = 0;
        chk("valid", 1, vld);
    endtask : rq
    task automatic t_prot;
        pe = 1; seg = 0; bsel = 0;
        wr(0, 0, 32'h0000_1000); wr(1, 0, 32'h0001_0000);
        rq(0, 1, 0, 1, 2, 32'h0000_0004);
        chk("addr", 32'h0001_1004, addr);
        chk("limit", 32'hfffe_ffff, lim);
        chk("paging", 0, tpg);
        pg = 1;
        rq(0, 1, 0, 1, 2, 32'h0000_0004);
        chk("paging", 1, tpg);
        chk("addr", 32'h0001_1004, addr);
        $display("t_prot done");
    endtask : t_prot
    // each of the seven non-empty offset combinations at every scale, base wraps past 2^32
    task automatic t_mix;
        pg = 0; seg = 1; bsel = 1; isel = 2;
        wr(0, 1, 32'hffff_ff00); wr(0, 2, 32'h0000_0003); wr(1, 1, 32'h0000_0200);
        for (int k = 1; k < 8; k++) for (int s = 0; s < 4; s++) begin
            rq(0, k[2], k[1], k[0], s[1:0], 32'h0000_0010);
            chk("addr", 32'h0000_0200 + (k[2] ? 32'hffff_ff00 : 0) + (k[1] ? 32'h3 << s : 0) + (k[0] ? 32'h10 : 0),
                addr);
            chk("lanes", s == 0 ? 1 : s == 1 ? 3 : 32'hf, be);
        end
        $display("t_mix done");
    endtask : t_mix
    task automatic t_real;
        pe = 0; seg = 2; bsel = 3;
        wr(1, 2, 32'h0000_ffff); wr(0, 3, 32'h0000_0010);
        rq(0, 1, 0, 1, 2, 32'h0001_ffe0);
        chk("addr", 32'h0010_ffe0, addr);
        chk("sel", 32'h0000_ffff, sel);
        chk("attr", 32'h0000_0fff, attr);
        $display("t_real done");
    endtask : t_real
    task automatic t_sp;
        pe = 1; seg = 0; bsel = 0; isel = 4;
        wr(0, 4, 32'h0000_0100);
        rq(0, 1, 1, 0, 0, 0);
        chk("addr", 32'h0001_1000, addr);
        chk("fault", 1, ifl);
        $display("t_sp done");
    endtask : t_sp
    task automatic t_port;
        pg = 1;
        for (int p = 32'h22; p < 32'h25; p++) begin
            rq(1, 0, 0, 1, 0, 32'habcd_0000 | p);
            chk("mio", 0, mio);
            chk("cfg", p != 32'h24, cfg);
            @(negedge i_clk);
            chk("port", p, pa);
        end
        $display("t_port done");
    endtask : t_port
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    // main sequence
    initial begin
        repeat (12) @(negedge i_clk);
        i_rstn = 1;
        repeat (3) @(negedge i_clk);
        t_prot; t_mix; t_real; t_sp; t_port;
        test_done;
    end
    // watchdog at 2000 cycles, far beyond the roughly 61 cycles needed
    initial begin
        #100000;
        n_fail++;
        test_done;
    end
endmodule : test_address_generation_unit
